// ### ddw_pkg.sv
// Purpose: shared types and constants for the dual converter write controller
// Assumes: one 25 MHz system clock
// Notes: pin timing counts are in system clock cycles
package ddw_pkg;
  // ----------------------------------------
  // timing
  // ----------------------------------------
  localparam int unsigned CLK_PERIOD_NS = 40;
  localparam int unsigned SETUP_NS = 80;
  localparam int unsigned PULSE_NS = 120;
  localparam int unsigned HOLD_NS = 40;
  localparam int unsigned SETUP_CYC = (SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned PULSE_CYC = (PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned HOLD_CYC = (HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned CODE_W = 8;
  // ----------------------------------------
  // write styles and channel masks
  // ----------------------------------------
  localparam logic [1:0] MODE_STROBE = 2'h0;
  localparam logic [1:0] MODE_SELECT_ONLY = 2'h1;
  localparam logic [1:0] MODE_TIED = 2'h2;
  localparam logic [1:0] CH_FIRST = 2'h1;
  localparam logic [1:0] CH_SECOND = 2'h2;
  localparam logic [1:0] CH_BOTH = 2'h3;
  // ----------------------------------------
  // carriers
  // ----------------------------------------
  typedef struct packed {
    logic [1:0] mode;
    logic [1:0] chans;
    logic [CODE_W-1:0] code;
  } ddw_req_t;
  typedef struct packed {
    logic load_strobe_n;
    logic select_first_channel_n;
    logic select_second_channel_n;
    logic [CODE_W-1:0] input_code_bits;
  } ddw_pins_t;
  typedef enum logic [1:0] {ST_IDLE, ST_SETUP, ST_PULSE, ST_HOLD} ddw_state_t;
endpackage : ddw_pkg

// ### ddw_host.sv
// Purpose: host-side write controller driving a dual 8-bit converter latch port
// Assumes: converter latches are transparent while strobe and select are low
// Notes: one request makes one write cycle; no read-back exists
// Notes on behaviour
// - each channel written through its own select
// - strobe may stay low, select latches
// - both selects low loads both channels
// - strobe tied to select, one pulse
`timescale 1ns/1ps
`default_nettype none
module ddw_host (
  input wire logic sys_clk_i,
  input wire logic sys_rst_i,
  input wire logic req_valid_i,
  input wire ddw_pkg::ddw_req_t req_i,
  output logic req_ready_o,
  output logic done_o,
  output var ddw_pkg::ddw_pins_t pins_o
);
  import ddw_pkg::*;

  // ----------------------------------------
  // sequencer
  // ----------------------------------------
  ddw_state_t state;
  ddw_state_t next_state;
  ddw_req_t cur;
  logic [3:0] cnt;
  ddw_pins_t next_pins;
  logic next_done;

  wire cnt_end = (cnt == 4'h0);
  wire take = (state == ST_IDLE) && req_valid_i;
  wire active = (state == ST_PULSE);
  wire strobe_low = (cur.mode == MODE_SELECT_ONLY) ? 1'b1 : active;
  wire sel1_low = active && cur.chans[0];
  wire sel2_low = active && cur.chans[1];
  assign req_ready_o = (state == ST_IDLE);

  function automatic logic [3:0] cyc(input int unsigned n);
    cyc = 4'(n - 1);
  endfunction : cyc

  always_comb begin
    next_state = state;
    case (state)
      ST_IDLE: begin
        if (take) begin
          next_state = ST_SETUP;
        end
      end
      ST_SETUP: begin
        if (cnt_end) begin
          next_state = ST_PULSE;
        end
      end
      ST_PULSE: begin
        if (cnt_end) begin
          next_state = ST_HOLD;
        end
      end
      ST_HOLD: begin
        if (cnt_end) begin
          next_state = ST_IDLE;
        end
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
  end

  always_comb begin
    next_pins.input_code_bits = cur.code;
    // tied style drives strobe and select as one pulse
    next_pins.load_strobe_n = ~strobe_low;
    next_pins.select_first_channel_n = ~sel1_low;
    next_pins.select_second_channel_n = ~sel2_low;
    next_done = (state == ST_HOLD) && cnt_end;
  end

  always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      state <= ST_IDLE;
      cnt <= 4'h0;
      cur <= '0;
    end else begin
      state <= next_state;
      if (take) begin
        cur <= req_i;
        cnt <= cyc(SETUP_CYC);
      end else if (state == ST_SETUP && cnt_end) begin
        cnt <= cyc(PULSE_CYC);
      end else if (state == ST_PULSE && cnt_end) begin
        cnt <= cyc(HOLD_CYC);
      end else if (!cnt_end) begin
        cnt <= cnt - 4'h1;
      end
    end
  end

  always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      pins_o <= '{load_strobe_n: 1'b1, select_first_channel_n: 1'b1,
                  select_second_channel_n: 1'b1, input_code_bits: '0};
      done_o <= 1'b0;
    end else begin
      pins_o <= next_pins;
      done_o <= next_done;
    end
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  logic [3:0] low_run;
  always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      low_run <= 4'h0;
    end else if (!pins_o.select_first_channel_n || !pins_o.select_second_channel_n) begin
      low_run <= low_run + 4'h1;
    end else begin
      low_run <= 4'h0;
    end
  end

  AST_SEL_PULSE_LEN: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
    low_run <= 4'(PULSE_CYC))
    else $error("select held low too long");
  AST_DATA_STABLE: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
    $rose(pins_o.select_first_channel_n) |-> $stable(pins_o.input_code_bits))
    else $error("data moved at latch edge");
  AST_FIRST_ONLY: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
    take && req_i.chans == CH_FIRST |-> ##(SETUP_CYC + 2) !pins_o.select_first_channel_n
      && pins_o.select_second_channel_n)
    else $error("wrong select for first channel");
  AST_BOTH: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
    take && req_i.chans == CH_BOTH |-> ##(SETUP_CYC + 2) !pins_o.select_first_channel_n
      && !pins_o.select_second_channel_n)
    else $error("both selects not low together");
  AST_STROBE_LOW: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
    state != ST_IDLE && cur.mode == MODE_SELECT_ONLY |=> !pins_o.load_strobe_n)
    else $error("strobe not held low");
  AST_TIED: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
    cur.mode == MODE_TIED && cur.chans == CH_SECOND && state != ST_IDLE
      |=> pins_o.load_strobe_n == pins_o.select_second_channel_n)
    else $error("tied strobe differs from select");
  AST_HOLD_IDLE: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
    state == ST_IDLE && $past(state) == ST_IDLE |=> pins_o.select_first_channel_n
      && pins_o.select_second_channel_n)
    else $error("select low while idle");
  AST_DONE: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
    take |-> ##(SETUP_CYC + PULSE_CYC + HOLD_CYC + 1) done_o)
    else $error("write cycle length wrong");
  AST_CODE: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
    take |-> ##(SETUP_CYC + 1) pins_o.input_code_bits == $past(req_i.code, SETUP_CYC + 1))
    else $error("code bits wrong");

  // ----------------------------------------
  // handshake and pin shape checks
  // ----------------------------------------
  AST_SECOND_ONLY: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
    take && req_i.chans == CH_SECOND |-> ##(SETUP_CYC + 2) pins_o.select_first_channel_n
      && !pins_o.select_second_channel_n)
    else $error("wrong select for second channel");
  AST_NO_CHAN: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
    take && req_i.chans == 2'h0 |-> ##(SETUP_CYC + 2) pins_o.select_first_channel_n
      && pins_o.select_second_channel_n)
    else $error("select low with no channel asked");
  AST_OPEN_FIRST: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
    !pins_o.select_first_channel_n |-> !pins_o.load_strobe_n)
    else $error("first select low without strobe");
  AST_OPEN_SECOND: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
    !pins_o.select_second_channel_n |-> !pins_o.load_strobe_n)
    else $error("second select low without strobe");
  AST_CODE_STEADY: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
    !pins_o.select_first_channel_n || !pins_o.select_second_channel_n
      |-> $stable(pins_o.input_code_bits))
    else $error("code moved while a latch is open");
  AST_STABLE_SECOND: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
    $rose(pins_o.select_second_channel_n) |-> $stable(pins_o.input_code_bits))
    else $error("data moved at second latch edge");
  AST_PULSE_FIRST: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
    $rose(pins_o.select_first_channel_n) |-> low_run == 4'(PULSE_CYC))
    else $error("first select pulse length wrong");
  AST_PULSE_SECOND: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
    $rose(pins_o.select_second_channel_n) |-> low_run == 4'(PULSE_CYC))
    else $error("second select pulse length wrong");
  AST_CLOSE_FIRST: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
    cur.mode != MODE_SELECT_ONLY && $rose(pins_o.select_first_channel_n)
      |-> $rose(pins_o.load_strobe_n))
    else $error("strobe and first select rise apart");
  AST_CLOSE_SECOND: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
    cur.mode != MODE_SELECT_ONLY && $rose(pins_o.select_second_channel_n)
      |-> $rose(pins_o.load_strobe_n))
    else $error("strobe and second select rise apart");
  AST_READY_BUSY: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
    take |=> !req_ready_o [*6] ##1 req_ready_o)
    else $error("ready wrong during write cycle");
  AST_DONE_ONCE: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
    done_o |=> !done_o)
    else $error("done longer than one cycle");
  AST_STROBE_IDLE: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
    state == ST_IDLE && cur.mode != MODE_SELECT_ONLY |=> pins_o.load_strobe_n)
    else $error("strobe low while idle");
  AST_SELONLY_IDLE: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
    state == ST_IDLE && cur.mode == MODE_SELECT_ONLY
      |=> !pins_o.load_strobe_n)
    else $error("strobe released in select only style");

  COV_FIRST: cover property (@(posedge sys_clk_i) take && req_i.chans == CH_FIRST);
  COV_BOTH: cover property (@(posedge sys_clk_i) take && req_i.chans == CH_BOTH);
  COV_SELONLY: cover property (@(posedge sys_clk_i) take && req_i.mode == MODE_SELECT_ONLY);
  COV_B2B: cover property (@(posedge sys_clk_i) done_o ##1 take);
  COV_TIED: cover property (@(posedge sys_clk_i) take && req_i.mode == MODE_TIED);
endmodule : ddw_host
`default_nettype wire

// ### ddw_dev_model.sv
// Purpose: behavioural dual converter latch port
// Assumes: a latch is open while strobe and its select are low
// Notes: codes go to the bench only
`timescale 1ns/1ps
`default_nettype none
module ddw_dev_model (
  input wire ddw_pkg::ddw_pins_t pins_i,
  output logic [7:0] first_code_o,
  output logic [7:0] second_code_o
);
  import ddw_pkg::*;
  // ----------------------------------------
  // channel latches
  // ----------------------------------------
  wire open_first = !pins_i.load_strobe_n && !pins_i.select_first_channel_n;
  wire open_second = !pins_i.load_strobe_n && !pins_i.select_second_channel_n;
  always_latch begin
    if (open_first) first_code_o <= pins_i.input_code_bits;
  end
  always_latch begin
    if (open_second) second_code_o <= pins_i.input_code_bits;
  end
endmodule : ddw_dev_model
`default_nettype wire

// ### ddw_host_tb_top.sv
// Purpose: random writes through the host into the latch model
// Assumes: done_o pulses six cycles after a take
// Notes: expected codes kept as integers
`timescale 1ns/1ps
`default_nettype none
module ddw_host_tb_top;
  import ddw_pkg::*;
  // ----------------------------------------
  // signals
  // ----------------------------------------
  logic sys_clk_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic req_valid_i = 1'b0;
  ddw_req_t req_i = '0;
  logic req_ready_o, done_o;
  ddw_pins_t pins_o;
  logic [7:0] c1, c2;
  int miscompares = 0;
  int cmp_count = 0;
  int cyc = 0;
  int e1, e2, lat;
  always #20 sys_clk_i = ~sys_clk_i;
  ddw_host ddw_host_inst (.sys_clk_i(sys_clk_i), .sys_rst_i(sys_rst_i),
    .req_valid_i(req_valid_i), .req_i(req_i), .req_ready_o(req_ready_o),
    .done_o(done_o), .pins_o(pins_o));
  ddw_dev_model ddw_dev_model_inst (.pins_i(pins_o), .first_code_o(c1), .second_code_o(c2));
  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task automatic close_out();
    $display("compares %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : close_out
  task automatic cmp_code(input string what, input int e, input logic [7:0] s);
    cmp_count++;
    if (s !== 8'(e)) begin
      miscompares++;
      $display("[ERR] %s exp %h seen %h", what, 8'(e), s);
    end
  endtask : cmp_code
  task automatic cmp_bit(input string what, input logic e, input logic s);
    cmp_count++;
    if (s !== e) begin
      miscompares++;
      $display("[ERR] %s exp %b seen %b", what, e, s);
    end
  endtask : cmp_bit
  task automatic cmp_lat(input int e, input int s);
    cmp_count++;
    if (s != e) begin
      miscompares++;
      $display("[ERR] latency exp %0d seen %0d", e, s);
    end
  endtask : cmp_lat
  task automatic wr(input logic [1:0] m, input logic [1:0] ch, input logic [7:0] d);
    @(posedge sys_clk_i);
    req_valid_i <= 1'b1;
    req_i <= '{mode: m, chans: ch, code: d};
    @(posedge sys_clk_i);
    req_valid_i <= 1'b0;
    lat = 0;
    do begin
      @(posedge sys_clk_i);
      #1;
      lat++;
      if (lat == 1) cmp_bit("ready_busy", 1'b0, req_ready_o);
      if (lat == SETUP_CYC + PULSE_CYC && ch[0]) cmp_code("open_first", d, c1);
      if (lat == SETUP_CYC + PULSE_CYC && ch[1]) cmp_code("open_second", d, c2);
      if (lat == SETUP_CYC + PULSE_CYC && !ch[0]) cmp_code("hold_first", e1, c1);
      if (lat == SETUP_CYC + PULSE_CYC && !ch[1]) cmp_code("hold_second", e2, c2);
    end while (done_o !== 1'b1 && lat < 20);
    if (ch[0]) e1 = d;
    if (ch[1]) e2 = d;
    cmp_lat(int'(SETUP_CYC + PULSE_CYC + HOLD_CYC), lat);
    cmp_bit("ready_idle", 1'b1, req_ready_o);
    cmp_code("first", e1, c1);
    cmp_code("second", e2, c2);
  endtask : wr
  // ----------------------------------------
  // run
  // ----------------------------------------
  always @(posedge sys_clk_i) begin
    cyc++;
    if (cyc == 3000) begin
      miscompares++;
      close_out();
    end
  end
  initial begin
    void'($urandom(63756));
    repeat (2) @(posedge sys_clk_i);
    sys_rst_i <= 1'b0;
    for (int m = 0; m < 3; m++) begin
      wr(2'(m), CH_BOTH, 8'h5a ^ 8'(m));
    end
    repeat (80) begin
      wr(2'($urandom_range(2)), 2'($urandom_range(3)), 8'($urandom));
    end
    @(posedge sys_clk_i);
    sys_rst_i <= 1'b1;
    repeat (2) @(posedge sys_clk_i);
    sys_rst_i <= 1'b0;
    #1;
    cmp_bit("ready_after_reset", 1'b1, req_ready_o);
    cmp_bit("strobe_after_reset", 1'b1, pins_o.load_strobe_n);
    repeat (4) begin
      wr(2'($urandom_range(2)), 2'($urandom_range(3)), 8'($urandom));
    end
    close_out();
  end
endmodule : ddw_host_tb_top
`default_nettype wire
